// ==== rtl/dps_pkg.sv ====
package dps_pkg;
	localparam int ADDR_W = 18;
	localparam int DATA_W = 18;
	localparam int BYTE_N = 2;
	localparam int BYTE0_LSB = 0;
	localparam int BYTE0_MSB = 8;
	localparam int BYTE1_LSB = 9;
	localparam int BYTE1_MSB = 17;
	localparam int ARRAY_DEPTH = 262144;
	localparam int CLK_PERIOD_NS = 40;
	localparam int RD_WORD0_CYC = 3;
	localparam int RD_WORD1_CYC = 4;
	localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
	localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
	localparam logic [BYTE_N-1:0] BSEL_RST = 2'h3;
	typedef logic [ADDR_W-1:0] dps_addr_t;
	typedef logic [DATA_W-1:0] dps_word_t;
	typedef logic [BYTE_N-1:0] dps_bsel_t;
endpackage

// ==== rtl/dps_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface dps_if;
	import dps_pkg::*;
	logic k;
	logic k_n;
	logic c;
	logic c_n;
	dps_addr_t addr;
	dps_word_t d;
	logic write_port_select_n;
	logic read_port_select_n;
	dps_bsel_t byte_write_select_n;
	dps_word_t q;
	logic q_oe;
	modport dev (
		input k, k_n, c, c_n, addr, d, write_port_select_n,
		input read_port_select_n, byte_write_select_n,
		output q, q_oe
	);
	modport ctl (
		output k, k_n, c, c_n, addr, d, write_port_select_n,
		output read_port_select_n, byte_write_select_n,
		input q, q_oe
	);
endinterface
`default_nettype wire

// ==== rtl/dps_sram.sv ====
// Summary of operation
// RULE1: write data captured on both input clocks
// RULE2: write select low on k starts write
// RULE3: deselected write port ignores data
// RULE4: byte selects sampled with data, 8:0/17:9
// RULE5: unselected byte keeps stored value
// RULE6: read address on k, write on k_n
// RULE7: address ignored when port deselected
// RULE8: two arrays of 256k words, 18 bits
// RULE9: read data on output or input clocks
// RULE10: read select low on k starts read
// RULE11: every read bursts two words
// RULE12: deselect: finish read, then tristate
// RULE13: accesses start only on k
// RULE14: write carries two words, own byte selects
`timescale 1ns/1ns
`default_nettype none
module dps_sram (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// memory pins
	dps_if.dev mem
);
	import dps_pkg::*;

	// lane merge: a lane with its select high keeps the stored bits
	function automatic dps_word_t merge(input dps_word_t old_w,
		input dps_word_t new_w, input dps_bsel_t sel_n);
		dps_word_t r;
		r = old_w;
		if (!sel_n[0]) begin
			r[BYTE0_MSB:BYTE0_LSB] = new_w[BYTE0_MSB:BYTE0_LSB];
		end
		if (!sel_n[1]) begin
			r[BYTE1_MSB:BYTE1_LSB] = new_w[BYTE1_MSB:BYTE1_LSB];
		end
		return r;
	endfunction

	// two half arrays: word 0 of a location in lo, word 1 in hi
	dps_word_t array_lo [0:ARRAY_DEPTH-1];
	dps_word_t array_hi [0:ARRAY_DEPTH-1];

	// write port state
	logic wr_pend_reg;
	logic wr_pend_next;
	dps_word_t wr_d0_reg;
	dps_word_t wr_d0_next;
	dps_bsel_t wr_bsel0_reg;
	dps_bsel_t wr_bsel0_next;

	// read port state
	logic rd_pend_reg;
	logic rd_pend_next;
	dps_addr_t rd_pend_addr_reg;
	dps_addr_t rd_pend_addr_next;
	logic rd_act_reg;
	logic rd_act_next;
	dps_addr_t rd_act_addr_reg;
	dps_addr_t rd_act_addr_next;
	dps_word_t q_reg;
	dps_word_t q_next;
	logic q_oe_reg;
	logic q_oe_next;

	// clock phases
	wire k_phase = mem.k;
	wire kn_phase = mem.k_n;
	wire single_clk = mem.c & mem.c_n;
	wire out_pos = single_clk ? mem.k : mem.c; // [RULE9]
	wire out_neg = single_clk ? mem.k_n : mem.c_n; // [RULE9]

	// access starts and burst steps
	wire wr_start = k_phase & ~mem.write_port_select_n; // [RULE2] [RULE13]
	wire rd_start = k_phase & ~mem.read_port_select_n; // [RULE10] [RULE13]
	wire wr_commit = kn_phase & wr_pend_reg; // [RULE3] [RULE6]
	wire rd_load0 = out_pos & rd_pend_reg; // [RULE11]
	wire rd_load1 = out_neg & rd_act_reg & ~out_pos; // [RULE11]

	// shared address bus
	wire [ADDR_W-1:0] wr_addr = mem.addr; // [RULE6]
	wire [ADDR_W-1:0] rd_addr = mem.addr; // [RULE6]

	// lane merged words for the location being written
	dps_word_t wr_lo_word;
	dps_word_t wr_hi_word;
	assign wr_lo_word = merge(array_lo[wr_addr], wr_d0_reg,
		wr_bsel0_reg); // [RULE5] [RULE8] [RULE14]
	assign wr_hi_word = merge(array_hi[wr_addr], mem.d,
		mem.byte_write_select_n); // [RULE1] [RULE4] [RULE5] [RULE14]

	// write port next values
	assign wr_pend_next = k_phase ? wr_start
		: (kn_phase ? 1'b0 : wr_pend_reg); // [RULE3] [RULE7]
	assign wr_d0_next = wr_start ? mem.d : wr_d0_reg; // [RULE1]
	assign wr_bsel0_next = wr_start ? mem.byte_write_select_n
		: wr_bsel0_reg; // [RULE4]

	// read request and burst tracking
	assign rd_pend_next = rd_start | (rd_pend_reg & ~out_pos); // [RULE12]
	assign rd_pend_addr_next = rd_start ? rd_addr
		: rd_pend_addr_reg; // [RULE6] [RULE7]
	assign rd_act_next = out_pos ? rd_pend_reg
		: (out_neg ? 1'b0 : rd_act_reg); // [RULE11]
	assign rd_act_addr_next = out_pos ? rd_pend_addr_reg
		: rd_act_addr_reg;

	// output register and its enable
	assign q_oe_next = out_pos ? rd_pend_reg : q_oe_reg; // [RULE12]
	assign q_next = rd_load0 ? array_lo[rd_pend_addr_reg]
		: (rd_load1 ? array_hi[rd_act_addr_reg]
		: q_reg); // [RULE11]

	// write pending flag
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wr_pend_reg <= 1'b0;
		end else begin
			wr_pend_reg <= wr_pend_next;
		end
	end

	// word 0 of a write
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wr_d0_reg <= DATA_RST;
		end else begin
			wr_d0_reg <= wr_d0_next;
		end
	end

	// lane selects of word 0
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wr_bsel0_reg <= BSEL_RST;
		end else begin
			wr_bsel0_reg <= wr_bsel0_next;
		end
	end

	// read pending flag
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rd_pend_reg <= 1'b0;
		end else begin
			rd_pend_reg <= rd_pend_next;
		end
	end

	// pending read address
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rd_pend_addr_reg <= ADDR_RST;
		end else begin
			rd_pend_addr_reg <= rd_pend_addr_next;
		end
	end

	// burst in flight flag
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rd_act_reg <= 1'b0;
		end else begin
			rd_act_reg <= rd_act_next;
		end
	end

	// address of the burst in flight
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rd_act_addr_reg <= ADDR_RST;
		end else begin
			rd_act_addr_reg <= rd_act_addr_next;
		end
	end

	// read data register
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			q_reg <= DATA_RST;
		end else begin
			q_reg <= q_next;
		end
	end

	// read data enable
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			q_oe_reg <= 1'b0;
		end else begin
			q_oe_reg <= q_oe_next;
		end
	end

	// array update, both halves of a location on the k_n phase
	always_ff @(posedge ref_clk) begin
		if (wr_commit) begin
			array_lo[wr_addr] <= wr_lo_word; // [RULE8]
			array_hi[wr_addr] <= wr_hi_word; // [RULE8]
		end
	end

	// read data pins
	assign mem.q = q_reg;
	assign mem.q_oe = q_oe_reg;
endmodule // dps_sram
`default_nettype wire

// ==== rtl/dps_ctrl.sv ====
`timescale 1ns/1ns
`default_nettype none
module dps_ctrl (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// configuration
	input wire logic single_clk_mode,
	// write requests
	input wire logic wr_valid,
	output logic wr_ready,
	input wire dps_pkg::dps_addr_t wr_addr,
	input wire logic [2*dps_pkg::DATA_W-1:0] wr_data,
	input wire logic [2*dps_pkg::BYTE_N-1:0] wr_be_n,
	// read requests
	input wire logic rd_valid,
	output logic rd_ready,
	input wire dps_pkg::dps_addr_t rd_addr,
	output logic [2*dps_pkg::DATA_W-1:0] rd_data,
	output logic rd_data_valid,
	// memory pins
	dps_if.ctl mem
);
	import dps_pkg::*;

	logic phase_reg;
	logic wsel_n_reg;
	logic rsel_n_reg;
	dps_addr_t addr_reg;
	dps_word_t d_reg;
	dps_bsel_t bsel_reg;
	dps_addr_t wa_hold_reg;
	dps_word_t wd_hold_reg;
	dps_bsel_t wb_hold_reg;
	logic [RD_WORD1_CYC-1:0] rd_track_reg;
	logic [2*DATA_W-1:0] rd_data_reg;
	logic rd_data_valid_reg;

	// requests are taken in the cycle before a k phase
	wire slot = ~phase_reg;
	wire wr_take = slot & wr_valid; // [RULE13]
	wire rd_take = slot & rd_valid; // [RULE13]
	wire k_rd_issued = phase_reg & ~rsel_n_reg;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			phase_reg <= 1'b0;
			wsel_n_reg <= 1'b1;
			rsel_n_reg <= 1'b1;
			addr_reg <= ADDR_RST;
			d_reg <= DATA_RST;
			bsel_reg <= BSEL_RST;
			wa_hold_reg <= ADDR_RST;
			wd_hold_reg <= DATA_RST;
			wb_hold_reg <= BSEL_RST;
		end else begin
			phase_reg <= ~phase_reg;
			if (slot) begin
				wsel_n_reg <= ~wr_take; // [RULE2]
				rsel_n_reg <= ~rd_take; // [RULE10]
				addr_reg <= rd_addr; // [RULE6]
				d_reg <= wr_data[DATA_W-1:0]; // [RULE1] [RULE14]
				bsel_reg <= wr_take ? wr_be_n[BYTE_N-1:0]
					: BSEL_RST; // [RULE4]
				wa_hold_reg <= wr_addr;
				wd_hold_reg <= wr_data[2*DATA_W-1:DATA_W];
				wb_hold_reg <= wr_take ? wr_be_n[2*BYTE_N-1:BYTE_N]
					: BSEL_RST;
			end else begin
				wsel_n_reg <= 1'b1;
				rsel_n_reg <= 1'b1;
				addr_reg <= wa_hold_reg; // [RULE6]
				d_reg <= wd_hold_reg; // [RULE1] [RULE14]
				bsel_reg <= wb_hold_reg; // [RULE4]
			end
		end
	end

	// read return: words arrive a fixed count after the k phase
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rd_track_reg <= '0;
			rd_data_reg <= '0;
			rd_data_valid_reg <= 1'b0;
		end else begin
			rd_track_reg <= {rd_track_reg[RD_WORD1_CYC-2:0], k_rd_issued};
			if (rd_track_reg[RD_WORD0_CYC-1] && mem.q_oe) begin
				rd_data_reg[DATA_W-1:0] <= mem.q; // [RULE9] [RULE11]
			end
			if (rd_track_reg[RD_WORD1_CYC-1] && mem.q_oe) begin
				rd_data_reg[2*DATA_W-1:DATA_W] <= mem.q; // [RULE11]
			end
			rd_data_valid_reg <= rd_track_reg[RD_WORD1_CYC-1];
		end
	end

	assign wr_ready = slot;
	assign rd_ready = slot;
	assign rd_data = rd_data_reg;
	assign rd_data_valid = rd_data_valid_reg;
	assign mem.k = phase_reg;
	assign mem.k_n = ~phase_reg;
	assign mem.c = single_clk_mode | phase_reg; // [RULE9]
	assign mem.c_n = single_clk_mode | ~phase_reg; // [RULE9]
	assign mem.addr = addr_reg;
	assign mem.d = d_reg;
	assign mem.write_port_select_n = wsel_n_reg;
	assign mem.read_port_select_n = rsel_n_reg;
	assign mem.byte_write_select_n = bsel_reg;
endmodule // dps_ctrl
`default_nettype wire

// ==== bench/dps_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
module dps_checker (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// memory pins
	input wire logic k,
	input wire logic k_n,
	input wire logic write_port_select_n,
	input wire logic read_port_select_n,
	input wire dps_pkg::dps_bsel_t byte_write_select_n,
	input wire logic q_oe
);
	import dps_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic [2:0] gap_reg;
	wire rd_sel = k && !read_port_select_n;
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			gap_reg <= 3'h7;
		else if (rd_sel)
			gap_reg <= 3'h0;
		else if (gap_reg != 3'h7)
			gap_reg <= gap_reg + 3'h1;
	end
	sequence rd_start;
		k && !read_port_select_n;
	endsequence
	sequence rd_burst;
		q_oe [*2];
	endsequence
	a_k_toggle: assert property (k |=> !k)
		else $error("input clock phase did not alternate");
	a_clk_pair: assert property (k != k_n)
		else $error("input clock pair not complementary");
	a_rsel_kphase: assert property (!k |-> read_port_select_n)
		else $error("read select low outside k phase");
	a_wsel_kphase: assert property (!k |-> write_port_select_n)
		else $error("write select low outside k phase");
	a_rd_two_words: assert property (rd_start |-> ##3 rd_burst)
		else $error("read burst not two words");
	a_oe_release: assert property (q_oe |-> gap_reg < 3'h4)
		else $error("read data driven too long after deselect");
	a_oe_cause: assert property ($rose(q_oe) |-> $past(rd_sel, 3))
		else $error("read data driven without read select");
	a_bsel_idle: assert property (k && write_port_select_n |->
		byte_write_select_n == 2'h3 ##1 byte_write_select_n == 2'h3)
		else $error("byte selects active with write deselected");
endmodule // dps_checker
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import dps_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic single_clk_mode = 1'b0;
	logic wr_valid = 1'b0;
	logic rd_valid = 1'b0;
	logic wr_ready, rd_ready, rd_data_valid;
	dps_addr_t wr_addr = '0;
	dps_addr_t rd_addr = '0;
	logic [35:0] wr_data = '0;
	logic [35:0] rd_data;
	logic [3:0] wr_be_n = 4'hF;
	int num_errors = 0;
	int n_tests = 0;
	dps_if mem_if();
	always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
	dps_sram dps_sram_inst (.ref_clk(ref_clk), .rst_n(rst_n), .mem(mem_if));
	dps_ctrl dps_ctrl_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.single_clk_mode(single_clk_mode), .wr_valid(wr_valid),
		.wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
		.wr_be_n(wr_be_n), .rd_valid(rd_valid), .rd_ready(rd_ready),
		.rd_addr(rd_addr), .rd_data(rd_data),
		.rd_data_valid(rd_data_valid), .mem(mem_if));
	dps_checker dps_checker_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.k(mem_if.k), .k_n(mem_if.k_n),
		.write_port_select_n(mem_if.write_port_select_n),
		.read_port_select_n(mem_if.read_port_select_n),
		.byte_write_select_n(mem_if.byte_write_select_n),
		.q_oe(mem_if.q_oe));
	task automatic chk(input logic [35:0] e, input logic [35:0] g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("Error t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic wr(input dps_addr_t a, input logic [35:0] v,
		input logic [3:0] b);
		@(negedge ref_clk);
		wr_addr = a;
		wr_data = v;
		wr_be_n = b;
		wr_valid = 1'b1;
		while (wr_ready !== 1'b1) @(negedge ref_clk);
		@(negedge ref_clk);
		wr_valid = 1'b0;
	endtask
	task automatic rd(input dps_addr_t a, input logic [35:0] e);
		@(negedge ref_clk);
		rd_addr = a;
		rd_valid = 1'b1;
		while (rd_ready !== 1'b1) @(negedge ref_clk);
		@(negedge ref_clk);
		rd_valid = 1'b0;
		for (int i = 0; i < 8 && rd_data_valid !== 1'b1; i++)
			@(negedge ref_clk);
		chk(36'h000000001, {35'h000000000, rd_data_valid});
		chk(e, rd_data);
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#400000;
		num_errors++;
		summarize;
	end
	initial begin
		repeat (20) @(negedge ref_clk);
		rst_n = 1'b1;
		wr(18'h00005, 36'h123456789, 4'h0);
		rd(18'h00005, 36'h123456789);
		$display("test 1 done");
		wr(18'h00005, 36'h000000000, 4'h6);
		rd(18'h00005, {18'h000D1, 18'h16600});
		$display("test 2 done");
		wr(18'h3FFFF, {18'h3FFFF, 18'h00001}, 4'h0);
		rd(18'h3FFFF, {18'h3FFFF, 18'h00001});
		rd(18'h00005, {18'h000D1, 18'h16600});
		$display("test 3 done");
		single_clk_mode = 1'b1;
		rd(18'h3FFFF, {18'h3FFFF, 18'h00001});
		$display("test 4 done");
		summarize;
	end
endmodule // tb_top
`default_nettype wire
